// >>> design/rmpu_pkg.sv
// package for the region memory protection unit
// assumes an axi4-lite register bus with 32-bit data
package rmpu_pkg;
  localparam int unsigned NUM_REGIONS = 8;
  localparam logic [11:0] PROT_BASE_OFF = 12'h000;
  localparam logic [11:0] CACHE_BASE_OFF = 12'h040;
  localparam logic [11:0] CTRL_OFF = 12'h080;
  localparam logic [11:0] STATUS_OFF = 12'h084;
  localparam int unsigned BASE_LSB = 10;
  localparam int unsigned PERM_RD_POS = 7;
  localparam int unsigned PERM_WR_POS = 6;
  localparam int unsigned CACHE_FLAG_POS = 6;
  localparam int unsigned SIZE_LSB = 1;
  localparam int unsigned EN_POS = 0;
  localparam logic [31:0] PROT_MASK = 32'hffff_fcff;
  localparam logic [31:0] CACHE_MASK = 32'hffff_fc7f;
  localparam logic [31:0] PROT_RESET = 32'h0000_00c0;
  localparam logic [31:0] CACHE_RESET = 32'h0000_0000;
  localparam logic [4:0] SIZE_MAX = 5'h0e;
  localparam int unsigned CTRL_PROT_POS = 1;
  localparam int unsigned CTRL_CACHE_POS = 0;
  localparam logic [3:0] BLK_FREE_LO = 4'h5;
  localparam logic [3:0] BLK_FREE_HI = 4'h9;
  localparam logic [3:0] BLK_TCM = 4'ha;
  localparam logic [3:0] BLK_CACHE_HI = 4'h3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : rmpu_pkg

// >>> design/rmpu_top.sv
// region memory protection and cacheability unit with axi4-lite registers
// assumes a processor access port on the same clock, one access per cycle
// What this block does
// RULE1 - a forbidden access is blocked and an abort goes to the processor
// RULE2 - eight programmable protection regions, each with read and write permission
// RULE3 - eight programmable cacheable regions, each cacheable or not
// RULE4 - address space split in sixteen 256MB blocks by the top four bits
// RULE5 - blocks five to nine always get full read and write
// RULE6 - blocks zero to four and ten use the protection regions
// RULE7 - with the protection check enabled, any access to blocks eleven to fifteen aborts
// RULE8 - block four and above non-cacheable; blocks zero to three use regions
// RULE9 - unmatched address in a protected block gets full read and write
// RULE10 - unmatched address in blocks zero to three is uncacheable
// RULE11 - software keeps enabled regions of one kind from overlapping
// RULE12 - software places protection regions only in blocks zero to four and ten
// RULE13 - software places cacheable regions only in blocks zero to three
// RULE14 - protection register: base 31:10, zeros 9:8, perm 7:6, size 5:1, enable 0
// RULE15 - cacheable register: base 31:10, zeros 9:7, flag 6, size 5:1, enable 0
// RULE16 - size code gives 1KB shifted by code, base bits 31 down to 10+code; codes above 14 act as 14 (16MB)
// RULE17 - software aligns each base to a multiple of the region size
// RULE18 - permission upper bit grants read, lower bit grants write
// RULE19 - software should use permission codes 00, 10 or 01
// RULE20 - cacheable flag one marks cacheable, zero uncacheable
// RULE21 - protection and cacheable regions are evaluated independently; an aborted access reports non-cacheable
// RULE22 - cacheable access reports group of regions zero to three or four to seven
// RULE23 - protection check disabled means no restriction and no abort
// RULE24 - cacheability check disabled means everything non-cacheable
// RULE25 - a region matches only when enabled and upper address bits equal base
// RULE26 - abort for read needs read bit clear, for write needs write bit clear
`timescale 1ns/1ns
module rmpu_top #(
  parameter int unsigned NUM_REGIONS = rmpu_pkg::NUM_REGIONS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        acc_valid,
  input  wire logic [31:0] acc_addr,
  input  wire logic        acc_write,
  output logic             acc_done,
  output logic             acc_abort,
  output logic             acc_cacheable,
  output logic             acc_cache_hi_group
);
  initial begin
    if (NUM_REGIONS != 8) $error("rmpu_top supports exactly eight regions per kind");
  end

  logic [31:0] prot_r [NUM_REGIONS];
  logic [31:0] cache_r [NUM_REGIONS];
  logic        prot_en_r;
  logic        cache_en_r;
  logic [31:0] abort_cnt_r;

  // region match on enable and the base bits above the size
  function automatic logic reg_match(input logic [31:0] cfg, input logic [31:0] addr);
    logic [4:0]  sz;
    logic [31:0] msk;
    sz = cfg[5:1];
    if (sz > rmpu_pkg::SIZE_MAX) sz = rmpu_pkg::SIZE_MAX;
    msk = 32'hffff_fc00 << sz; // RULE16
    return cfg[rmpu_pkg::EN_POS] && ((addr & msk) == (cfg & msk)); // RULE25
  endfunction : reg_match

  // access decode
  wire [3:0] blk = acc_addr[31:28]; // RULE4
  wire blk_free = (blk >= rmpu_pkg::BLK_FREE_LO) && (blk <= rmpu_pkg::BLK_FREE_HI); // RULE5
  wire blk_dead = blk > rmpu_pkg::BLK_TCM; // RULE7
  wire blk_prot = !blk_free && !blk_dead; // RULE6
  wire blk_cach = blk <= rmpu_pkg::BLK_CACHE_HI; // RULE8

  logic [NUM_REGIONS-1:0] p_hit;
  logic [NUM_REGIONS-1:0] c_hit;
  logic [NUM_REGIONS-1:0] p_deny;
  logic [NUM_REGIONS-1:0] c_flag;
  always_comb begin
    for (int i = 0; i < NUM_REGIONS; i++) begin
      p_hit[i] = reg_match(prot_r[i], acc_addr); // RULE2
      c_hit[i] = reg_match(cache_r[i], acc_addr); // RULE3
      // RULE18 RULE26
      p_deny[i] = acc_write ? !prot_r[i][rmpu_pkg::PERM_WR_POS] :
                              !prot_r[i][rmpu_pkg::PERM_RD_POS];
      c_flag[i] = cache_r[i][rmpu_pkg::CACHE_FLAG_POS]; // RULE20
    end
  end

  // unmatched protected address denies nothing
  wire region_deny = |(p_hit & p_deny); // RULE9
  wire deny = prot_en_r && (blk_dead || (blk_prot && region_deny)); // RULE1 RULE23
  // groups evaluated apart from protection
  wire c_lo = |(c_hit[3:0] & c_flag[3:0]); // RULE21
  wire c_hi = |(c_hit[7:4] & c_flag[7:4]);
  wire cachable = cache_en_r && blk_cach && (c_lo || c_hi); // RULE10 RULE24

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_done <= 1'b0;
      acc_abort <= 1'b0;
      acc_cacheable <= 1'b0;
      acc_cache_hi_group <= 1'b0;
    end else begin
      acc_done <= acc_valid;
      acc_abort <= acc_valid && deny; // RULE1
      acc_cacheable <= acc_valid && cachable && !deny;
      acc_cache_hi_group <= acc_valid && cachable && !deny && c_hi; // RULE22
    end
  end

  // axi4-lite write path
  logic        aw_held_r;
  logic        w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  wire [11:0] wa = awaddr_r;
  wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire wr_prot = (wa[11:5] == rmpu_pkg::PROT_BASE_OFF[11:5]) && (wa[1:0] == 2'b00);
  wire wr_cach = (wa[11:5] == rmpu_pkg::CACHE_BASE_OFF[11:5]) && (wa[1:0] == 2'b00);
  wire wr_ctrl = wa == rmpu_pkg::CTRL_OFF;
  wire wr_stat = wa == rmpu_pkg::STATUS_OFF;
  wire wr_ok = wr_prot || wr_cach || wr_ctrl || wr_stat;
  wire [2:0] widx = wa[4:2];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (aw_take) awaddr_r <= s_axi_awaddr;
      if (w_take) wdata_r <= s_axi_wdata;
      if (w_take) wstrb_r <= s_axi_wstrb;
      aw_held_r <= wr_fire ? 1'b0 : (aw_held_r || aw_take);
      w_held_r <= wr_fire ? 1'b0 : (w_held_r || w_take);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rmpu_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !w_take && !s_axi_bvalid;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? rmpu_pkg::RESP_OKAY : rmpu_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register storage with reserved zero bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGIONS; i++) begin
        prot_r[i] <= rmpu_pkg::PROT_RESET;
        cache_r[i] <= rmpu_pkg::CACHE_RESET;
      end
      prot_en_r <= 1'b0;
      cache_en_r <= 1'b0;
    end else if (wr_fire) begin
      // RULE14
      if (wr_prot) prot_r[widx] <= ((prot_r[widx] & ~wmask) | (wdata_r & wmask))
                                   & rmpu_pkg::PROT_MASK;
      // RULE15
      if (wr_cach) cache_r[widx] <= ((cache_r[widx] & ~wmask) | (wdata_r & wmask))
                                    & rmpu_pkg::CACHE_MASK;
      if (wr_ctrl && wstrb_r[0]) begin
        prot_en_r <= wdata_r[rmpu_pkg::CTRL_PROT_POS];
        cache_en_r <= wdata_r[rmpu_pkg::CTRL_CACHE_POS];
      end
    end
  end

  // abort counter, write clears, an abort in the same cycle as the clear leaves a count of one
  wire abort_evt = acc_valid && deny;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      abort_cnt_r <= 32'h0000_0000;
    end else if (abort_evt) begin
      abort_cnt_r <= (wr_fire && wr_stat) ? 32'h0000_0001 : abort_cnt_r + 32'h0000_0001;
    end else if (wr_fire && wr_stat) begin
      abort_cnt_r <= 32'h0000_0000;
    end
  end

  // axi4-lite read path
  wire [11:0] ra = s_axi_araddr;
  wire rd_prot = (ra[11:5] == rmpu_pkg::PROT_BASE_OFF[11:5]) && (ra[1:0] == 2'b00);
  wire rd_cach = (ra[11:5] == rmpu_pkg::CACHE_BASE_OFF[11:5]) && (ra[1:0] == 2'b00);
  wire rd_ctrl = ra == rmpu_pkg::CTRL_OFF;
  wire rd_stat = ra == rmpu_pkg::STATUS_OFF;
  wire [2:0] ridx = ra[4:2];
  wire [31:0] ctrl_word = {30'h0000_0000, prot_en_r, cache_en_r};
  wire [31:0] rd_word = rd_prot ? prot_r[ridx] :
                        rd_cach ? cache_r[ridx] :
                        rd_ctrl ? ctrl_word :
                        rd_stat ? abort_cnt_r : 32'h0000_0000;
  wire rd_ok = rd_prot || rd_cach || rd_ctrl || rd_stat;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rmpu_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? rmpu_pkg::RESP_OKAY : rmpu_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  property p_dead_block;
    @(posedge clk) disable iff (rst)
      (acc_valid && prot_en_r && acc_addr[31:28] > 4'ha) |=> acc_abort;
  endproperty
  a_dead_block: assert property (p_dead_block) else $error("high block not aborted"); // RULE7

  property p_free_block;
    @(posedge clk) disable iff (rst)
      (acc_valid && acc_addr[31:28] inside {[4'h5:4'h9]}) |=> !acc_abort;
  endproperty
  a_free_block: assert property (p_free_block) else $error("free block aborted"); // RULE5

  property p_prot_off;
    @(posedge clk) disable iff (rst) !$past(prot_en_r) |-> !acc_abort;
  endproperty
  a_prot_off: assert property (p_prot_off) else $error("abort with check off"); // RULE23

  property p_cache_off;
    @(posedge clk) disable iff (rst) !$past(cache_en_r) |-> !acc_cacheable;
  endproperty
  a_cache_off: assert property (p_cache_off) else $error("cacheable with check off"); // RULE24

  property p_high_uncached;
    @(posedge clk) disable iff (rst) (acc_valid && acc_addr[31:28] > 4'h3) |=> !acc_cacheable;
  endproperty
  a_high_uncached: assert property (p_high_uncached) else $error("block four up cached"); // RULE8

  property p_abort_done;
    @(posedge clk) disable iff (rst) acc_abort |-> acc_done && !acc_cacheable;
  endproperty
  a_abort_done: assert property (p_abort_done) else $error("abort without access"); // RULE1

  property p_group;
    @(posedge clk) disable iff (rst) acc_cache_hi_group |-> acc_cacheable;
  endproperty
  a_group: assert property (p_group) else $error("group flag without cacheable"); // RULE22

  property p_unmatched;
    @(posedge clk) disable iff (rst)
      (acc_valid && p_hit == '0 && acc_addr[31:28] <= 4'ha) |=> !acc_abort;
  endproperty
  a_unmatched: assert property (p_unmatched) else $error("unmatched address aborted"); // RULE9

  property p_bresp;
    @(posedge clk) disable iff (rst) wr_fire |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write not answered"); // RULE14

  c_abort: cover property (@(posedge clk) disable iff (rst) acc_abort);
  c_cached_lo: cover property (@(posedge clk) disable iff (rst)
    acc_cacheable && !acc_cache_hi_group);
  c_cached_hi: cover property (@(posedge clk) disable iff (rst) acc_cache_hi_group);
endmodule : rmpu_top

// >>> tb/rmpu_cpu_model.sv
// processor side model: one access at a time on the access port
// assumes the unit answers exactly one cycle after an access is taken
`timescale 1ns/1ns
module rmpu_cpu_model (
  input  wire logic        clk,
  output logic             acc_valid,
  output logic [31:0]      acc_addr,
  output logic             acc_write,
  input  wire logic        acc_done,
  input  wire logic        acc_abort,
  input  wire logic        acc_cacheable,
  input  wire logic        acc_cache_hi_group
);
  initial begin
    acc_valid = 1'b0;
    acc_addr  = 32'h0000_0000;
    acc_write = 1'b0;
  end
  // result is {done, abort, cacheable, hi group}, taken while the answer stands
  task automatic access(input logic [31:0] a, input logic w, output logic [3:0] res);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_addr  <= a;
    acc_write <= w;
    @(posedge clk);
    acc_valid <= 1'b0;
    acc_addr  <= ~a;
    acc_write <= ~w;
    #1;
    res = {acc_done, acc_abort, acc_cacheable, acc_cache_hi_group};
  endtask : access
endmodule : rmpu_cpu_model

// >>> tb/test_region_memory_protection.sv
// bench for the protection unit: axi4-lite master tasks and a processor model
// assumes register offsets of rmpu_pkg and a one-cycle access answer
`timescale 1ns/1ns
module test_region_memory_protection;
  logic        clk = 1'b0, rst = 1'b1;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, dv;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic        acc_valid, acc_write, done, abort, cach, hi;
  logic [31:0] acc_addr;
  int          fail_count = 0, total_checks = 0;
  always #25 clk = ~clk;
  rmpu_top i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write), .acc_done(done),
    .acc_abort(abort), .acc_cacheable(cach), .acc_cache_hi_group(hi));
  rmpu_cpu_model i_cpu (.clk(clk), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .acc_write(acc_write), .acc_done(done), .acc_abort(abort), .acc_cacheable(cach),
    .acc_cache_hi_group(hi));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    rs = bresp;
    bready <= 1'b0;
    if (n >= 50) fail_count++;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) fail_count++;
  endtask : rd
  function automatic logic [11:0] pa(input int i);
    return rmpu_pkg::PROT_BASE_OFF + 12'(4 * i);
  endfunction : pa
  function automatic logic [11:0] ca(input int i);
    return rmpu_pkg::CACHE_BASE_OFF + 12'(4 * i);
  endfunction : ca
  // region words: base 31:10, attribute, size code, enable set
  function automatic logic [31:0] pv(input logic [31:0] b, input logic [1:0] p,
                                     input logic [4:0] s);
    return {b[31:10], 2'b00, p, s, 1'b1};
  endfunction : pv
  function automatic logic [31:0] cv(input logic [31:0] b, input logic f, input logic [4:0] s);
    return {b[31:10], 3'b000, f, s, 1'b1};
  endfunction : cv
  task automatic acc(input string nm, input logic [31:0] a, input logic w, input logic [3:0] e);
    logic [3:0] res;
    i_cpu.access(a, w, res);
    check(nm, {28'h0, res}, {28'h0, e});
  endtask : acc
  task automatic t_reset;
    rd(pa(0), dv, rs);
    check("prot reset", dv, rmpu_pkg::PROT_RESET);
    rd(ca(3), dv, rs);
    check("cache reset", dv, rmpu_pkg::CACHE_RESET);
    acc("checks off top block", 32'hb000_0000, 1'b0, 4'b1000);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_fields;
    wr(pa(2), 32'hffff_ffff);
    check("prot bresp", {30'h0, rs}, {30'h0, rmpu_pkg::RESP_OKAY});
    rd(pa(2), dv, rs);
    check("prot fields", dv, rmpu_pkg::PROT_MASK);
    wr(ca(2), 32'hffff_ffff);
    rd(ca(2), dv, rs);
    check("cache fields", dv, rmpu_pkg::CACHE_MASK);
    wr(pa(2), rmpu_pkg::PROT_RESET);
    wr(ca(2), 32'h0000_0000);
    rd(12'h100, dv, rs);
    check("unmapped resp", {30'h0, rs}, {30'h0, rmpu_pkg::RESP_SLVERR});
    wr(12'h100, 32'h0000_0000);
    check("unmapped bresp", {30'h0, rs}, {30'h0, rmpu_pkg::RESP_SLVERR});
    $display("t_fields done");
  endtask : t_fields
  task automatic t_blocks;
    wr(rmpu_pkg::CTRL_OFF, 32'h0000_0003);
    wr(rmpu_pkg::STATUS_OFF, 32'h0000_0000);
    for (int b = 0; b < 16; b++) begin
      acc("block", {4'(b), 28'h123_4560}, 1'b1, {1'b1, b >= 11, 2'b00});
    end
    rd(rmpu_pkg::STATUS_OFF, dv, rs);
    check("abort count", dv, 32'h0000_0005);
    $display("t_blocks done");
  endtask : t_blocks
  task automatic t_prot_all;
    for (int i = 0; i < 8; i++) begin
      wr(pa(i), pv(32'(i) << 20, 2'b00, 5'h00));
      acc("region hit", 32'(i) << 20, 1'b0, 4'b1100);
      acc("region edge", (32'(i) << 20) + 32'h400, 1'b0, 4'b1000);
      wr(pa(i), rmpu_pkg::PROT_RESET);
      acc("region off", 32'(i) << 20, 1'b0, 4'b1000);
    end
    $display("t_prot_all done");
  endtask : t_prot_all
  task automatic t_perm;
    wr(pa(0), pv(32'ha000_0000, 2'b10, 5'h03));
    wr(pa(1), pv(32'h4000_0000, 2'b01, 5'h00));
    acc("ro read", 32'ha000_1ffc, 1'b0, 4'b1000);
    acc("ro write", 32'ha000_1ffc, 1'b1, 4'b1100);
    acc("past 8k", 32'ha000_2000, 1'b1, 4'b1000);
    acc("wo read", 32'h4000_0000, 1'b0, 4'b1100);
    acc("wo write", 32'h4000_03fc, 1'b1, 4'b1000);
    wr(pa(0), rmpu_pkg::PROT_RESET);
    wr(pa(1), rmpu_pkg::PROT_RESET);
    $display("t_perm done");
  endtask : t_perm
  task automatic t_cache;
    wr(ca(0), cv(32'h0000_0000, 1'b1, 5'h0e));
    wr(ca(5), cv(32'h1000_0000, 1'b1, 5'h00));
    wr(ca(6), cv(32'h2000_0000, 1'b0, 5'h0e));
    wr(pa(3), pv(32'h0000_0000, 2'b10, 5'h0e));
    acc("low group", 32'h00ff_fffc, 1'b0, 4'b1010);
    acc("abort no cache", 32'h0000_0004, 1'b1, 4'b1100);
    acc("high group", 32'h1000_03fc, 1'b0, 4'b1011);
    acc("cache miss", 32'h1000_0400, 1'b0, 4'b1000);
    acc("flag zero", 32'h2000_0000, 1'b0, 4'b1000);
    acc("past 16m", 32'h0100_0000, 1'b0, 4'b1000);
    wr(rmpu_pkg::CTRL_OFF, 32'h0000_0001);
    acc("prot off write", 32'h0000_0004, 1'b1, 4'b1010);
    acc("prot off top", 32'hb000_0000, 1'b0, 4'b1000);
    wr(rmpu_pkg::CTRL_OFF, 32'h0000_0002);
    acc("cache off", 32'h0000_0000, 1'b0, 4'b1000);
    $display("t_cache done");
  endtask : t_cache
  initial begin
    #(50 * 20000);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_fields();
    t_blocks();
    t_prot_all();
    t_perm();
    t_cache();
    tally_and_finish();
  end
endmodule : test_region_memory_protection
